/* atm_pkg.sv */
// Purpose: shared constants for the address trap monitor
// Assumes: 50 MHz system clock, APB register offsets below
// Notes: area bounds are plain defaults, set per memory map
package atm_pkg;
  // ************************************************
  // clock and reset timing
  // ************************************************
  localparam int CLK_HZ = 50_000_000;
  localparam int FC_HZ = 50_000_000;
  localparam int FC_CLK_DIV = (CLK_HZ + FC_HZ - 1) / FC_HZ;
  localparam int RST_FC_PERIODS = 24;
  localparam int RST_MAX_CLK = RST_FC_PERIODS * FC_CLK_DIV;
  // ************************************************
  // register offsets (byte addresses)
  // ************************************************
  localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
  localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
  localparam logic [7:0] OFS_INT_STATUS = 8'h08;
  localparam logic [7:0] OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] OFS_STATE = 8'h10;
  // ************************************************
  // fields and codes
  // ************************************************
  localparam int BIT_RAM_SEL = 5;
  localparam int BIT_ACTION = 4;
  localparam logic RAM_SEL_RESET = 1'b1;
  localparam logic ACTION_RESET = 1'b1;
  localparam logic [7:0] CODE_APPLY_AREA = 8'hd2;
  localparam int BIT_EVT_IRQ = 0;
  localparam int BIT_EVT_RST = 1;
  localparam logic [1:0] INT_MASK_RESET = 2'h0;
  // ************************************************
  // monitored address areas
  // ************************************************
  localparam logic [15:0] SFR_LO = 16'h0000;
  localparam logic [15:0] SFR_HI = 16'h003f;
  localparam logic [15:0] RAM_LO = 16'h0040;
  localparam logic [15:0] RAM_HI = 16'h083f;
  localparam logic [15:0] DBR_LO = 16'h0f80;
  localparam logic [15:0] DBR_HI = 16'h0fff;
endpackage : atm_pkg

/* atm_area_match.sv */
// Purpose: inclusive address range comparator
// Assumes: bounds fixed at elaboration
// Notes: one instance per monitored area
`timescale 1ns/1ps
module atm_area_match #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff
) (
  input wire logic [15:0] addr,
  output logic hit
);
  // purely combinational window check
  assign hit = (addr >= LO) && (addr <= HI);
endmodule : atm_area_match

/* atm_pulse_timer.sv */
// Purpose: counts a fixed number of slow ticks after a start
// Assumes: tick is a one-cycle enable on clk
// Notes: first tick may come early, so length is a maximum
`timescale 1ns/1ps
module atm_pulse_timer #(
  parameter int TICKS = 24
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic tick,
  output logic busy
);
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic busy_reg;
  logic busy_next;
  // load on start, count ticks down, drop at zero
  assign cnt_next = start ? 5'(TICKS) :
                    (busy_reg && tick) ? cnt_reg - 5'h01 : cnt_reg;
  assign busy_next = start ? 1'b1 :
                     (busy_reg && tick && cnt_reg == 5'h01) ? 1'b0 : busy_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= 5'h00;
      busy_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      busy_reg <= busy_next;
    end
  end
  assign busy = busy_reg;
endmodule : atm_pulse_timer

/* atm_monitor.sv */
// Purpose: address trap monitor with APB control and status
// Assumes: fetch port on clk; reset pin is open drain
// Notes: control one and two are write-only, read as zero
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/1ps
module atm_monitor (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fetch_valid,
  input wire logic fetch_instr,
  input wire logic [15:0] fetch_addr,
  input wire logic low_speed_mode_one,
  output logic trap_interrupt,
  output logic reset_pin_o,
  output logic reset_pin_oe,
  output logic hw_reset,
  output logic hf_osc_restart,
  output logic irq
);
  typedef enum logic [0:0] {RS_IDLE, RS_HOLD} atm_rst_state_type;

  // ************************************************
  // declarations
  // ************************************************
  atm_rst_state_type state_reg;
  atm_rst_state_type state_next;
  logic ram_pend_reg;
  logic ram_eff_reg;
  logic action_reg;
  logic [1:0] status_reg;
  logic [1:0] status_next;
  logic [1:0] mask_reg;
  logic [15:0] last_addr_reg;
  logic trap_irq_reg;
  logic osc_restart_reg;
  logic [31:0] prdata_reg;
  logic [31:0] rd_mux;
  logic [$clog2(atm_pkg::FC_CLK_DIV+1)-1:0] div_reg;
  logic fc_tick;
  logic sfr_hit;
  logic dbr_hit;
  logic ram_hit;
  logic is_fetch;
  logic trap_hit;
  logic rst_start;
  logic busy;
  logic acc_wr;
  logic setup_rd;
  logic wr_one;
  logic wr_two;
  logic wr_stat;
  logic wr_mask;
  logic apply_area;
  logic addr_ok;
  logic [1:0] evt;

  // ************************************************
  // area decode
  // ************************************************
  atm_area_match #(.LO(atm_pkg::SFR_LO), .HI(atm_pkg::SFR_HI)) u_sfr (
    .addr(fetch_addr),
    .hit(sfr_hit)
  );
  atm_area_match #(.LO(atm_pkg::DBR_LO), .HI(atm_pkg::DBR_HI)) u_dbr (
    .addr(fetch_addr),
    .hit(dbr_hit)
  );
  atm_area_match #(.LO(atm_pkg::RAM_LO), .HI(atm_pkg::RAM_HI)) u_ram (
    .addr(fetch_addr),
    .hit(ram_hit)
  );

  // trap qualification; fetches are ignored while the reset is held
  assign is_fetch = fetch_valid && fetch_instr && (state_reg == RS_IDLE);
  assign trap_hit = is_fetch && (sfr_hit || dbr_hit ||
                    (ram_hit && ram_eff_reg));
  assign rst_start = trap_hit && action_reg;

  // ************************************************
  // apb decode
  // ************************************************
  assign acc_wr = psel && penable && pwrite;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_one = acc_wr && (paddr == atm_pkg::OFS_CTRL_ONE);
  assign wr_two = acc_wr && (paddr == atm_pkg::OFS_CTRL_TWO);
  assign wr_stat = acc_wr && (paddr == atm_pkg::OFS_INT_STATUS);
  assign wr_mask = acc_wr && (paddr == atm_pkg::OFS_INT_MASK);
  // unlisted codes fall through with no effect
  assign apply_area = wr_two && (pwdata[7:0] == atm_pkg::CODE_APPLY_AREA);
  assign addr_ok = (paddr == atm_pkg::OFS_CTRL_ONE) || (paddr == atm_pkg::OFS_CTRL_TWO) ||
                   (paddr == atm_pkg::OFS_INT_STATUS) || (paddr == atm_pkg::OFS_INT_MASK) ||
                   (paddr == atm_pkg::OFS_STATE);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;

  // read mux; write-only controls return zero so no rmw trick works
  assign rd_mux = (paddr == atm_pkg::OFS_INT_STATUS) ? {30'h0, status_reg} :
                  (paddr == atm_pkg::OFS_INT_MASK) ? {30'h0, mask_reg} :
                  (paddr == atm_pkg::OFS_STATE) ? {last_addr_reg, 11'h0, osc_restart_reg,
                    busy, action_reg, ram_pend_reg, ram_eff_reg} : 32'h0;

  // read data captured in setup so it is stable for the access phase
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata_reg <= 32'h0;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // ************************************************
  // control registers
  // ************************************************
  // trap reset returns the controls to their power-on values
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ram_pend_reg <= atm_pkg::RAM_SEL_RESET;
      ram_eff_reg <= atm_pkg::RAM_SEL_RESET;
      action_reg <= atm_pkg::ACTION_RESET;
    end else if (busy) begin
      ram_pend_reg <= atm_pkg::RAM_SEL_RESET;
      ram_eff_reg <= atm_pkg::RAM_SEL_RESET;
      action_reg <= atm_pkg::ACTION_RESET;
    end else begin
      if (wr_one) begin
        ram_pend_reg <= pwdata[atm_pkg::BIT_RAM_SEL];
        action_reg <= pwdata[atm_pkg::BIT_ACTION];
      end
      if (apply_area) begin
        ram_eff_reg <= ram_pend_reg;
      end
    end
  end

  // ************************************************
  // interrupt status and mask
  // ************************************************
  assign evt = {rst_start, trap_hit && !action_reg};
  // set beats a simultaneous write-one clear
  assign status_next = (status_reg & ~(wr_stat ? pwdata[1:0] : 2'h0)) | evt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status_reg <= 2'h0;
      mask_reg <= atm_pkg::INT_MASK_RESET;
    end else begin
      status_reg <= status_next;
      if (wr_mask) begin
        mask_reg <= pwdata[1:0];
      end
    end
  end
  assign irq = |(status_reg & mask_reg);

  // ************************************************
  // trap interrupt request
  // ************************************************
  // no master flag gating: the cpu takes this as a non-maskable request
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      trap_irq_reg <= 1'b0;
      last_addr_reg <= 16'h0;
    end else begin
      trap_irq_reg <= trap_hit && !action_reg;
      if (trap_hit) begin
        last_addr_reg <= fetch_addr;
      end
    end
  end
  assign trap_interrupt = trap_irq_reg;

  // ************************************************
  // high-frequency clock enable
  // ************************************************
  // one pulse per fast clock period, free running
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= '0;
    end else if (fc_tick) begin
      div_reg <= '0;
    end else begin
      div_reg <= div_reg + 1'b1;
    end
  end
  assign fc_tick = (div_reg == ($bits(div_reg))'(atm_pkg::FC_CLK_DIV - 1));

  // ************************************************
  // trap reset sequencer
  // ************************************************
  // length counted in fast periods, hence at most the full count
  atm_pulse_timer #(.TICKS(atm_pkg::RST_FC_PERIODS)) u_rst_timer (
    .clk(clk),
    .nrst(nrst),
    .start(rst_start),
    .tick(fc_tick),
    .busy(busy)
  );

  assign state_next = (state_reg == RS_IDLE) ? (rst_start ? RS_HOLD : RS_IDLE) :
                      (busy ? RS_HOLD : RS_IDLE);
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= RS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // oscillator restart held for the whole pulse when in low-speed mode one
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      osc_restart_reg <= 1'b0;
    end else if (rst_start) begin
      osc_restart_reg <= low_speed_mode_one;
    end else if (!busy) begin
      osc_restart_reg <= 1'b0;
    end
  end

  // open-drain pin: only ever pulled low
  assign reset_pin_o = 1'b0;
  assign reset_pin_oe = busy;
  assign hw_reset = busy;
  assign hf_osc_restart = osc_restart_reg;

  // ************************************************
  // assertions
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  logic [7:0] hold_cnt_reg;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hold_cnt_reg <= 8'h00;
    end else begin
      hold_cnt_reg <= busy ? hold_cnt_reg + 8'h01 : 8'h00;
    end
  end

  AST_RAM_GATED: assert property (is_fetch && ram_hit && !sfr_hit && !dbr_hit && !ram_eff_reg
    |=> !trap_interrupt && !$rose(reset_pin_oe)) else $error("ram fetch trapped while select off");
  AST_AREA_APPLY: assert property (ram_eff_reg != $past(ram_eff_reg)
    |-> $past(apply_area) || $past(busy)) else $error("ram select changed without d2 code");
  AST_CODE_ONLY: assert property (wr_two && !apply_area && !busy
    |=> $stable(ram_eff_reg)) else $error("other control code changed area");
  AST_SFR_TRAP: assert property (is_fetch && (sfr_hit || dbr_hit) && !action_reg
    |=> trap_interrupt) else $error("sfr or buffer fetch not trapped");
  AST_IRQ_ACTION: assert property (trap_hit && !action_reg
    |=> trap_interrupt ##1 !trap_interrupt || $past(trap_hit, 1)) else $error("trap irq missing");
  AST_BACK_TO_BACK: assert property (trap_interrupt && trap_hit && !action_reg
    |=> trap_interrupt) else $error("repeated trap lost");
  AST_RST_ACTION: assert property (trap_hit && action_reg
    |=> reset_pin_oe && hw_reset && !trap_interrupt) else $error("trap reset not raised");
  AST_PIN_LOW: assert property (reset_pin_oe |-> !reset_pin_o && hw_reset)
    else $error("reset pin not pulled low");
  AST_RST_LEN: assert property (hold_cnt_reg <= 8'(atm_pkg::RST_MAX_CLK))
    else $error("trap reset too long");
  AST_OSC_RESTART: assert property ($rose(reset_pin_oe) && $past(low_speed_mode_one)
    |-> hf_osc_restart) else $error("oscillator not restarted");
  AST_DATA_IGNORED: assert property (fetch_valid && !fetch_instr
    |=> !trap_interrupt && !$rose(reset_pin_oe)) else $error("data access trapped");

  COV_SFR_IRQ: cover property (is_fetch && sfr_hit && !action_reg ##1 trap_interrupt);
  COV_RAM_RESET: cover property (is_fetch && ram_hit && action_reg ##1 reset_pin_oe);
  COV_APPLY: cover property (wr_one ##[1:8] apply_area);
  COV_SLOW_RST: cover property (rst_start && low_speed_mode_one);
endmodule : atm_monitor

/* atm_cpu_model.sv */
// Purpose: cpu instruction fetch path in front of the trap monitor
// Assumes: reset pin is open drain with a pull-up
// Notes: idle address bus shows the inverse of the last address
`timescale 1ns/1ps
module atm_cpu_model (
  input wire logic clk,
  input wire logic rst_pin_n,
  input wire logic req,
  input wire logic req_instr,
  input wire logic [15:0] req_addr,
  output logic fetch_valid,
  output logic fetch_instr,
  output logic [15:0] fetch_addr
);
  logic [15:0] last_addr = 16'h0000;
  logic sp_set = 1'b1;
  // cpu stalls while the reset pin is low, fetches only after sp set
  assign fetch_valid = req & rst_pin_n & sp_set;
  assign fetch_instr = req_instr;
  // released bus never repeats a stale address that could still match
  assign fetch_addr = fetch_valid ? req_addr : ~last_addr;
  // remember last driven address
  always_ff @(posedge clk) begin
    if (fetch_valid) begin
      last_addr <= req_addr;
    end
  end
endmodule : atm_cpu_model

/* address_trap_monitor_bench.sv */
// Purpose: self-checking bench for the address trap monitor
// Assumes: zero wait-state apb, fetch model drives the fetch port
// Notes: fc equals clk, so trap reset spans at most 24 cycles
`timescale 1ns/1ps
module address_trap_monitor_bench;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic req, req_instr, slow;
  logic [15:0] req_addr, fetch_addr;
  logic fetch_valid, fetch_instr, trap_interrupt, rst_o, rst_oe, hw_reset, osc_rst, irq, rst_pin_n;
  int fails, comparisons, n;
  // ************************************************
  // clock, pins, instances
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // open drain reset pin with pull-up
  assign rst_pin_n = rst_oe ? rst_o : 1'b1;
  atm_cpu_model u_cpu (.clk(clk), .rst_pin_n(rst_pin_n), .req(req), .req_instr(req_instr),
    .req_addr(req_addr), .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .fetch_addr(fetch_addr));
  atm_monitor u_dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .fetch_valid(fetch_valid), .fetch_instr(fetch_instr), .fetch_addr(fetch_addr),
    .low_speed_mode_one(slow), .trap_interrupt(trap_interrupt), .reset_pin_o(rst_o),
    .reset_pin_oe(rst_oe), .hw_reset(hw_reset), .hf_osc_restart(osc_rst), .irq(irq));
  // ************************************************
  // shared tasks
  // ************************************************
  task close_out;
    if (fails == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one apb transfer; waits for pready under a bound
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    // judge by pready itself so a late answer on the last try still counts
    if (pready !== 1'b1) begin
      fails++;
      close_out();
    end
    rd = prdata;
    check(pslverr, err);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // one fetch cycle, trap pulse looked at one cycle later
  task fetch(input logic [15:0] a, input logic ins, input logic exp_trap);
    @(posedge clk);
    req <= 1'b1;
    req_instr <= ins;
    req_addr <= a;
    @(posedge clk);
    req <= 1'b0;
    #1;
    check(trap_interrupt, exp_trap);
  endtask : fetch
  // ************************************************
  // scenarios
  // ************************************************
  task reset_values;
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    check(rd, 32'h7);
    apb(1'b0, 8'h00, 32'h0, 1'b0);
    check(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0, 1'b1);
  endtask : reset_values
  task irq_action;
    apb(1'b1, 8'h00, 32'h20, 1'b0);
    fetch(16'h0010, 1'b1, 1'b1);
    check(rst_oe, 1'b0);
    fetch(16'h0010, 1'b0, 1'b0);
    // back-to-back traps keep the trap pulse high for two cycles in a row
    @(posedge clk);
    req <= 1'b1;
    req_instr <= 1'b1;
    req_addr <= 16'h0f80;
    @(posedge clk);
    req_addr <= 16'h0fff;
    #1 check(trap_interrupt, 1'b1);
    @(posedge clk);
    req <= 1'b0;
    #1 check(trap_interrupt, 1'b1);
    @(posedge clk);
    #1 check(trap_interrupt, 1'b0);
    // status, mask and w1c
    check(irq, 1'b0);
    // mask and status settle just after the access edge, so look a step later
    apb(1'b1, 8'h0c, 32'h1, 1'b0);
    #1 check(irq, 1'b1);
    apb(1'b1, 8'h08, 32'h1, 1'b0);
    #1 check(irq, 1'b0);
  endtask : irq_action
  task ram_select;
    apb(1'b1, 8'h00, 32'h00, 1'b0);
    fetch(16'h0040, 1'b1, 1'b1);
    apb(1'b1, 8'h04, 32'h4e, 1'b0);
    fetch(16'h083f, 1'b1, 1'b1);
    apb(1'b1, 8'h04, 32'hd2, 1'b0);
    fetch(16'h083f, 1'b1, 1'b0);
    fetch(16'h003f, 1'b1, 1'b1);
  endtask : ram_select
  task reset_action;
    apb(1'b1, 8'h00, 32'h10, 1'b0);
    slow <= 1'b1;
    fetch(16'h0fff, 1'b1, 1'b0);
    check(rst_pin_n, 1'b0);
    check(hw_reset, 1'b1);
    check(osc_rst, 1'b1);
    n = 0;
    while (rst_oe === 1'b1 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    check(n <= 24, 1'b1);
    if (n >= 40) begin
      close_out();
    end
    slow <= 1'b0;
    // ram and sfr traps from the select scenario left the irq event set too
    apb(1'b0, 8'h08, 32'h0, 1'b0);
    check(rd, 32'h3);
    apb(1'b0, 8'h10, 32'h0, 1'b0);
    check(rd, 32'h0fff0007);
    fetch(16'h0040, 1'b1, 1'b0);
    check(rst_oe, 1'b1);
    check(osc_rst, 1'b0);
  endtask : reset_action
  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    fails = 0;
    comparisons = 0;
    nrst = 1'b0;
    {psel, penable, pwrite, req, req_instr, slow} = 6'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    req_addr = 16'h0000;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    reset_values();
    irq_action();
    ram_select();
    reset_action();
    close_out();
  end
endmodule : address_trap_monitor_bench
